// [verilog/dfsfl_top.sv]
// two-way queue pair with synchronised status flags and apb control
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

// Functional notes
// - word moved to output frees its location
// - output register word excluded from fill count
// - q2 offsets feed port a aempty, b afull
// - combined pins follow selected timing mode
// - full flag on writer clock, pointer advances
// - full comparator sees full, full-1, full-2
// - space flag rises second writer edge after read
// - late writer edge defers first sync cycle
// - almost-empty flag on reader clock
// - comparator sees threshold, plus one, plus two
// - almost-empty offset per queue, reader flag
// - almost-empty low at or below offset
// - almost-empty rises second reader edge after write
// - late reader edge defers first sync cycle
// - almost-full flag on writer clock
// - comparator sees threshold, minus one, minus two
// - almost-full offset per queue, writer flag
// - almost-full low at depth minus offset
// - almost-full rises second writer edge after read
// - late writer edge defers first sync cycle
// - writes ignored while no space is free
// - reads ignored while nothing ready, output held
// - fall-through word shows on third reader edge
// - standard empty flag rises on second edge
module dfsfl_top (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         porta_clock,
  input  wire logic                         porta_write_enable,
  input  wire logic                         porta_read_enable,
  input  wire logic [dfsfl_pkg::DATA_W-1:0] porta_data_in,
  output logic      [dfsfl_pkg::DATA_W-1:0] porta_data_out,
  output logic                              porta_full_flag,
  output logic                              porta_input_ready,
  output logic                              porta_almost_full,
  output logic                              porta_empty_flag,
  output logic                              porta_output_ready,
  output logic                              porta_almost_empty,
  input  wire logic                         portb_clock,
  input  wire logic                         portb_write_enable,
  input  wire logic                         portb_read_enable,
  input  wire logic [dfsfl_pkg::DATA_W-1:0] portb_data_in,
  output logic      [dfsfl_pkg::DATA_W-1:0] portb_data_out,
  output logic                              portb_full_flag,
  output logic                              portb_input_ready,
  output logic                              portb_almost_full,
  output logic                              portb_empty_flag,
  output logic                              portb_output_ready,
  output logic                              portb_almost_empty
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                               clk_prev; // last port clocks
    dfsfl_pkg::dfsfl_queue_type [1:0]         q;        // 0 = a to b
    logic [dfsfl_pkg::CTRL_W-1:0]             ctrl;     // mode, resets
    logic [1:0][dfsfl_pkg::OFF_W-1:0]         xoff;     // almost-empty
    logic [1:0][dfsfl_pkg::OFF_W-1:0]         yoff;     // almost-full
    logic [31:0]                              prdata;   // read data
  } dfsfl_top_state_type;

  localparam dfsfl_top_state_type TOP_RESET = '{
    q:    '{dfsfl_pkg::QUEUE_RESET, dfsfl_pkg::QUEUE_RESET},
    xoff: '{dfsfl_pkg::OFF_PRESET, dfsfl_pkg::OFF_PRESET},
    yoff: '{dfsfl_pkg::OFF_PRESET, dfsfl_pkg::OFF_PRESET},
    default: '0
  };

  dfsfl_top_state_type st_reg;   // registered state
  dfsfl_top_state_type st_next;  // next state

  // ------------------------------------------------------------------
  // pin synchronisers, one bundle per port
  // ------------------------------------------------------------------
  logic [dfsfl_pkg::BUS_W-1:0] pin_bus [2];  // raw pins
  logic [dfsfl_pkg::BUS_W-1:0] sync_bus [2]; // after two stages
  logic [1:0]                  sclk;         // synchronised port clocks
  logic [1:0]                  swr;          // synchronised write enables
  logic [1:0]                  srd;          // synchronised read enables
  logic [1:0]                  port_edge;    // port clock rising edge

  assign pin_bus[0] = {porta_clock, porta_write_enable, porta_read_enable,
                       porta_data_in};
  assign pin_bus[1] = {portb_clock, portb_write_enable, portb_read_enable,
                       portb_data_in};

  // clock, enables and data share one latency, so the enables and data
  // seen at a detected edge are the ones the far side set up for it
  for (genvar p = 0; p < 2; p++) begin : g_port
    dfsfl_sync #(
      .WIDTH (dfsfl_pkg::BUS_W)
    ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pin_bus[p]),
      .q       (sync_bus[p])
    );
    assign sclk[p] = sync_bus[p][dfsfl_pkg::BUS_CLK];
    assign swr[p]  = sync_bus[p][dfsfl_pkg::BUS_WR];
    assign srd[p]  = sync_bus[p][dfsfl_pkg::BUS_RD];
  end

  // a rising port edge is a pclk cycle where the clock goes 0 to 1
  assign port_edge = sclk & ~st_reg.clk_prev;

  // ------------------------------------------------------------------
  // per-queue request terms and memories
  // ------------------------------------------------------------------
  logic                         fall_through_select;                 // fall-through mode
  logic [1:0]                   qrst;                 // queue held reset
  logic [1:0]                   wr_edge;              // writer port edge
  logic [1:0]                   rd_edge;              // reader port edge
  logic [1:0]                   q_we;                 // accepted write
  logic [1:0]                   q_rd;                 // read request
  logic [1:0]                   q_take;               // word to output
  logic [dfsfl_pkg::DATA_W-1:0] wr_data [2];          // writer data
  logic [dfsfl_pkg::DATA_W-1:0] ram_rdata [2];        // head of memory
  logic [dfsfl_pkg::CNT_W-1:0]  cnt_w [2];            // fill, writer view
  logic [dfsfl_pkg::CNT_W-1:0]  cnt_r [2];            // fill, reader view
  logic [7:0]                   status;               // flag snapshot

  assign fall_through_select = st_reg.ctrl[dfsfl_pkg::CTRL_FALL_THROUGH];

  // queue i is written by port i and read by the other port
  for (genvar i = 0; i < 2; i++) begin : g_queue
    localparam int WP = i;
    localparam int RP = 1 - i;

    assign qrst[i]    = st_reg.ctrl[dfsfl_pkg::CTRL_QRST_BASE + i];
    assign wr_edge[i] = port_edge[WP];
    assign rd_edge[i] = port_edge[RP] & ~qrst[i];
    assign wr_data[i] = sync_bus[WP][dfsfl_pkg::DATA_W-1:0];

    // write taken only while space is free
    assign q_we[i] = wr_edge[i] & swr[WP] & st_reg.q[i].full_ok
                     & ~qrst[i];
    assign q_rd[i] = rd_edge[i] & srd[RP];

    // fall-through refills an empty output register unasked; standard
    // mode moves a word only on a read made while the flag is high
    assign q_take[i] = fall_through_select
      ? (rd_edge[i] & st_reg.q[i].nonempty
         & (~st_reg.q[i].ready | srd[RP]))
      : (q_rd[i] & st_reg.q[i].eor);

    dfsfl_ram u_ram (
      .pclk    (pclk),
      .wr_en   (q_we[i]),
      .wr_addr (st_reg.q[i].wptr[dfsfl_pkg::ADDR_W-1:0]),
      .wr_data (wr_data[i]),
      .rd_addr (st_reg.q[i].rptr[dfsfl_pkg::ADDR_W-1:0]),
      .rd_data (ram_rdata[i])
    );

    // status nibble per queue
    assign status[dfsfl_pkg::ST_STRIDE*i + dfsfl_pkg::ST_FULL]   =
      st_reg.q[i].full_ok;
    assign status[dfsfl_pkg::ST_STRIDE*i + dfsfl_pkg::ST_AFULL]  =
      st_reg.q[i].afull_n;
    assign status[dfsfl_pkg::ST_STRIDE*i + dfsfl_pkg::ST_EOR]    =
      st_reg.q[i].eor;
    assign status[dfsfl_pkg::ST_STRIDE*i + dfsfl_pkg::ST_AEMPTY] =
      st_reg.q[i].aempty_n;
  end

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  logic        mapped;  // address decodes to a register
  logic [31:0] rd_val;  // read value of the addressed register

  // flags are only recomputed on the port edge of their own clock, so
  // they stay still between edges whatever the other side does
  always_comb begin
    st_next          = st_reg;
    st_next.clk_prev = sclk;
    mapped           = 1'b1;
    rd_val           = 32'h0000_0000;

    for (int i = 0; i < 2; i++) begin
      // pointers advance on every accepted write and every word moved
      st_next.q[i].wptr  = st_reg.q[i].wptr
                           + dfsfl_pkg::PTR_W'(q_we[i]);
      st_next.q[i].rptr  = st_reg.q[i].rptr
                           + dfsfl_pkg::PTR_W'(q_take[i]);
      st_next.q[i].wgray = dfsfl_pkg::bin2gray(st_next.q[i].wptr);
      st_next.q[i].rgray = dfsfl_pkg::bin2gray(st_next.q[i].rptr);

      // writer side: the read pointer crosses in two stages, each
      // stage clocked by a writer edge, so a freed location shows on
      // the second edge; a read too close to an edge misses it
      if (wr_edge[i]) begin
        st_next.q[i].r2w1 = st_reg.q[i].rgray;
        st_next.q[i].r2w2 = st_reg.q[i].r2w1;
      end

      // fill counts hold memory words only, never the output register
      cnt_w[i] = {1'b0, st_next.q[i].wptr
                  - dfsfl_pkg::gray2bin(st_next.q[i].r2w2)};

      if (wr_edge[i]) begin
        // exact count, so full, full-1 and full-2 are told apart
        st_next.q[i].full_ok = cnt_w[i] < dfsfl_pkg::DEPTH;
        // almost full low from depth minus offset upward
        st_next.q[i].afull_n = (cnt_w[i] + dfsfl_pkg::CNT_W'(st_reg.yoff[i])
                                + dfsfl_pkg::CNT_ONE)
                               <= dfsfl_pkg::DEPTH;
      end

      // reader side: the write pointer crosses the same way
      if (rd_edge[i]) begin
        st_next.q[i].w2r1 = st_reg.q[i].wgray;
        st_next.q[i].w2r2 = st_reg.q[i].w2r1;
      end

      cnt_r[i] = {1'b0, dfsfl_pkg::gray2bin(st_next.q[i].w2r2)
                  - st_next.q[i].rptr};

      if (rd_edge[i]) begin
        st_next.q[i].nonempty = |cnt_r[i];
        // almost empty low up to and including the offset
        st_next.q[i].aempty_n = cnt_r[i]
                                > dfsfl_pkg::CNT_W'(st_reg.xoff[i]);
        // output valid while fall-through keeps a word there
        st_next.q[i].ready = fall_through_select & (q_take[i]
                             | (st_reg.q[i].ready & ~q_rd[i]));
        // pin meaning follows the mode
        st_next.q[i].eor = fall_through_select ? st_next.q[i].ready
                                : st_next.q[i].nonempty;
        // output holds the last word unless a word moves
        if (q_take[i]) begin
          st_next.q[i].dout = ram_rdata[i];
        end
      end

      // a held queue reset clears pointers and flags but keeps data
      if (qrst[i]) begin
        st_next.q[i]      = dfsfl_pkg::QUEUE_RESET;
        st_next.q[i].dout = st_reg.q[i].dout;
      end
    end

    // register decode
    case (paddr)
      dfsfl_pkg::ADDR_CTRL: begin
        rd_val = 32'(st_reg.ctrl);
      end
      dfsfl_pkg::ADDR_Q1_EOFF: begin
        rd_val = 32'(st_reg.xoff[0]);
      end
      dfsfl_pkg::ADDR_Q1_FOFF: begin
        rd_val = 32'(st_reg.yoff[0]);
      end
      dfsfl_pkg::ADDR_Q2_EOFF: begin
        rd_val = 32'(st_reg.xoff[1]);
      end
      dfsfl_pkg::ADDR_Q2_FOFF: begin
        rd_val = 32'(st_reg.yoff[1]);
      end
      dfsfl_pkg::ADDR_STATUS: begin
        rd_val = 32'(status);
      end
      default: begin
        // unmapped or unaligned: reads zero, answers with an error
        mapped = 1'b0;
      end
    endcase

    // read data is captured in the setup cycle so it leaves a flop
    if (psel & ~penable) begin
      st_next.prdata = rd_val;
    end

    // writes take effect in the access cycle
    if (psel & penable & pwrite) begin
      case (paddr)
        dfsfl_pkg::ADDR_CTRL: begin
          st_next.ctrl = pwdata[dfsfl_pkg::CTRL_W-1:0];
          // entering a queue reset reloads that queue's presets
          for (int k = 0; k < 2; k++) begin
            if (pwdata[dfsfl_pkg::CTRL_QRST_BASE + k]
                & ~st_reg.ctrl[dfsfl_pkg::CTRL_QRST_BASE + k]) begin
              st_next.xoff[k] = dfsfl_pkg::OFF_PRESET;
              st_next.yoff[k] = dfsfl_pkg::OFF_PRESET;
            end
          end
        end
        dfsfl_pkg::ADDR_Q1_EOFF: begin
          st_next.xoff[0] = pwdata[dfsfl_pkg::OFF_W-1:0];
        end
        dfsfl_pkg::ADDR_Q1_FOFF: begin
          st_next.yoff[0] = pwdata[dfsfl_pkg::OFF_W-1:0];
        end
        dfsfl_pkg::ADDR_Q2_EOFF: begin
          st_next.xoff[1] = pwdata[dfsfl_pkg::OFF_W-1:0];
        end
        dfsfl_pkg::ADDR_Q2_FOFF: begin
          st_next.yoff[1] = pwdata[dfsfl_pkg::OFF_W-1:0];
        end
        default: begin
          // status and unmapped addresses ignore writes
          st_next.ctrl = st_reg.ctrl;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // every flag lives in here, so no pin can glitch between edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= TOP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // zero-wait slave; the error answer is combinational from decode
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = st_reg.prdata;

  // port a writes queue 0 and reads queue 1
  assign porta_full_flag    = st_reg.q[0].full_ok;
  assign porta_input_ready  = st_reg.q[0].full_ok;
  assign porta_almost_full  = st_reg.q[0].afull_n;
  assign porta_empty_flag   = st_reg.q[1].eor;
  assign porta_output_ready = st_reg.q[1].eor;
  assign porta_almost_empty = st_reg.q[1].aempty_n;
  assign porta_data_out     = st_reg.q[1].dout;

  // port b writes queue 1 and reads queue 0
  assign portb_full_flag    = st_reg.q[1].full_ok;
  assign portb_input_ready  = st_reg.q[1].full_ok;
  assign portb_almost_full  = st_reg.q[1].afull_n;
  assign portb_empty_flag   = st_reg.q[0].eor;
  assign portb_output_ready = st_reg.q[0].eor;
  assign portb_almost_empty = st_reg.q[0].aempty_n;
  assign portb_data_out     = st_reg.q[0].dout;

endmodule

// [common/dfsfl_pkg.sv]
// package: sizes, register map, queue state type and pointer helpers
package dfsfl_pkg;

  // ------------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------------
  localparam int DATA_W = 36;          // word width of both queues
  localparam int PTR_W  = 9;           // pointer width, wrap bit on top
  localparam int ADDR_W = 8;           // memory address width
  localparam int OFF_W  = 8;           // offset register width
  localparam int CNT_W  = 10;          // fill count width
  localparam int BUS_W  = DATA_W + 3;  // synchronised pin bundle per port
  localparam logic [CNT_W-1:0] DEPTH      = 10'h100; // words per queue
  localparam logic [CNT_W-1:0] CNT_ONE    = 10'h001; // one word
  localparam logic [OFF_W-1:0] OFF_PRESET = 8'h08;   // offset after reset

  // ------------------------------------------------------------------
  // pin bundle layout
  // ------------------------------------------------------------------
  localparam int BUS_CLK = BUS_W - 1;  // port clock
  localparam int BUS_WR  = BUS_W - 2;  // queue write enable
  localparam int BUS_RD  = BUS_W - 3;  // queue read enable

  // ------------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_Q1_EOFF = 8'h04;
  localparam logic [7:0] ADDR_Q1_FOFF = 8'h08;
  localparam logic [7:0] ADDR_Q2_EOFF = 8'h0C;
  localparam logic [7:0] ADDR_Q2_FOFF = 8'h10;
  localparam logic [7:0] ADDR_STATUS  = 8'h14;
  localparam int CTRL_W            = 3;  // control width
  localparam int CTRL_FALL_THROUGH = 0;  // 1 = fall-through timing
  localparam int CTRL_QRST_BASE    = 1;  // bit 1 resets q1, bit 2 q2
  localparam int ST_FULL   = 0;          // status nibble layout
  localparam int ST_AFULL  = 1;
  localparam int ST_EOR    = 2;
  localparam int ST_AEMPTY = 3;
  localparam int ST_STRIDE = 4;

  // ------------------------------------------------------------------
  // per-queue state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [PTR_W-1:0]  wptr;      // write pointer, binary
    logic [PTR_W-1:0]  wgray;     // write pointer, gray
    logic [PTR_W-1:0]  r2w1;      // read pointer, first write-side stage
    logic [PTR_W-1:0]  r2w2;      // read pointer, second write-side stage
    logic [PTR_W-1:0]  rptr;      // read pointer, binary
    logic [PTR_W-1:0]  rgray;     // read pointer, gray
    logic [PTR_W-1:0]  w2r1;      // write pointer, first read-side stage
    logic [PTR_W-1:0]  w2r2;      // write pointer, second read-side stage
    logic              full_ok;   // space free, high active
    logic              afull_n;   // almost full, low active
    logic              nonempty;  // memory holds a word
    logic              aempty_n;  // almost empty, low active
    logic              ready;     // output register valid (fall-through)
    logic              eor;       // combined empty / output ready pin
    logic [DATA_W-1:0] dout;      // output register
  } dfsfl_queue_type;

  localparam dfsfl_queue_type QUEUE_RESET =
    '{full_ok: 1'b1, afull_n: 1'b1, default: '0};

  // ------------------------------------------------------------------
  // pointer encoding
  // ------------------------------------------------------------------
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// [verilog/dfsfl_sync.sv]
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module dfsfl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;    // first stage, read by stage two only
    logic [WIDTH-1:0] stable;  // second stage
  } dfsfl_sync_state_type;

  dfsfl_sync_state_type st_reg;
  dfsfl_sync_state_type st_next;

  // shift the pins through both stages
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = d;
    st_next.stable = st_reg.meta;
  end

  // register the copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.stable;

endmodule

// [verilog/dfsfl_ram.sv]
// queue memory: one write port, one asynchronous read port
`timescale 1ns/1ps
module dfsfl_ram (
  input  wire logic                         pclk,
  input  wire logic                         wr_en,
  input  wire logic [dfsfl_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [dfsfl_pkg::DATA_W-1:0] wr_data,
  input  wire logic [dfsfl_pkg::ADDR_W-1:0] rd_addr,
  output logic      [dfsfl_pkg::DATA_W-1:0] rd_data
);

  // storage, no reset: contents are don't-care until written
  logic [dfsfl_pkg::DATA_W-1:0] mem [int'(dfsfl_pkg::DEPTH)];

  // write on an accepted queue write
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read is combinational; the caller registers it
  assign rd_data = mem[rd_addr];

endmodule

// [testbench/dfsfl_sva.sv]
// checker: apb answers and flag relations at the queue pair pins
`timescale 1ns/1ps
module dfsfl_sva (
  input wire logic       pclk, presetn, psel, penable, pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic       pready, pslverr, porta_clock,
  input wire logic       porta_full_flag, porta_input_ready, porta_almost_full,
  input wire logic       portb_empty_flag, portb_output_ready, portb_almost_empty
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable; // access phase of a transfer
  ready_tied_a: assert property (pready) else $error("pready low");
  bad_addr_a: assert property (acc && !pwrite && paddr > 8'h14 |-> pslverr && prdata == 0)
    else $error("unmapped read not refused");
  odd_addr_a: assert property (acc && paddr[1:0] != 0 |-> pslverr) else $error("unaligned");
  good_addr_a: assert property (acc && paddr == 8'h04 |-> !pslverr) else $error("mapped err");
  ff_copy_a: assert property (porta_full_flag == porta_input_ready) else $error("ff");
  ef_copy_a: assert property (portb_empty_flag == portb_output_ready) else $error("ef");
  full_afull_a: assert property (!porta_full_flag |-> !porta_almost_full)
    else $error("full but not almost full");
  empty_aempty_a: assert property (!portb_empty_flag |-> !portb_almost_empty)
    else $error("empty but not almost empty");
  // a flag may move only a few cycles after its port clock rose
  ff_edge_a: assert property ($changed(porta_full_flag) |->
    $past(porta_clock, 2) || $past(porta_clock, 3))
    else $error("full flag moved off a port edge");
  cover property (!porta_full_flag);
  cover property (portb_almost_empty);
  cover property (acc && pslverr);
endmodule

// [testbench/dfsfl_port_model.sv]
// port master model: free port clock, writes while space, reads on request
`timescale 1ns/1ps
module dfsfl_port_model (
  input  wire logic        pclk,
  input  wire logic        wr_go,
  input  wire logic        rd_go,
  input  wire logic        space,
  output logic             port_clock,
  output logic             wr_en,
  output logic             rd_en,
  output logic [35:0]      data,
  output int               taken
);
  logic [1:0] div;
  initial {div, port_clock, wr_en, rd_en, data, taken} = '0;
  // port clock is 8 pclk; enables and data change at its falling edge only,
  // so nothing moves in the pclk cycle where the port clock rises
  always @(posedge pclk) begin
    div <= div + 2'd1;
    if (div == 2'd3) begin
      port_clock <= !port_clock;
      if (port_clock) begin
        wr_en <= wr_go && space;
        rd_en <= rd_go; // reads are not gated, so refusals get exercised
        data  <= 36'(taken); // word value is the count of transfers so far
      end else if ((wr_en && space) || rd_en) begin
        taken <= taken + 1;
      end
    end
  end
endmodule

// [testbench/dfsfl_top_bench.sv]
// bench: apb register rows, then fill and drain of the a-to-b queue
`timescale 1ns/1ps
module dfsfl_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic a_wr = 0, b_rd = 0, porta_write_enable, porta_read_enable, porta_clock;
  logic portb_write_enable, portb_read_enable, portb_clock;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [35:0] porta_data_in, porta_data_out, portb_data_in, portb_data_out;
  logic porta_full_flag, porta_input_ready, porta_almost_full, porta_empty_flag;
  logic porta_output_ready, porta_almost_empty, portb_full_flag, portb_input_ready;
  logic portb_almost_full, portb_empty_flag, portb_output_ready, portb_almost_empty;
  int err_total = 0, checks_done = 0, cyc = 0, na, nb;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} dfsfl_row_type;
  // reset contents of every register, plus refused addresses
  dfsfl_row_type rows [8] = '{'{8'h00, 32'h0000_0000, 0}, '{8'h04, 32'h0000_0008, 0},
    '{8'h08, 32'h0000_0008, 0}, '{8'h0C, 32'h0000_0008, 0}, '{8'h10, 32'h0000_0008, 0},
    '{8'h14, 32'h0000_0033, 0}, '{8'h18, 32'h0000_0000, 1}, '{8'h05, 32'h0000_0000, 1}};
  always #50 pclk = ~pclk;
  dfsfl_top u_dut (.*);
  dfsfl_port_model u_pa (.pclk(pclk), .wr_go(a_wr), .rd_go(1'b0), .space(porta_full_flag),
    .port_clock(porta_clock), .wr_en(porta_write_enable), .rd_en(porta_read_enable),
    .data(porta_data_in), .taken(na));
  dfsfl_port_model u_pb (.pclk(pclk), .wr_go(1'b0), .rd_go(b_rd), .space(1'b0),
    .port_clock(portb_clock), .wr_en(portb_write_enable), .rd_en(portb_read_enable),
    .data(portb_data_in), .taken(nb));
  task automatic chk(input string n, input logic [35:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) if (++cyc == 20000) begin
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    chk("reset flags", {porta_full_flag, porta_almost_full, portb_empty_flag}, 3'b110);
    chk("reset b side", {portb_full_flag, portb_input_ready, portb_almost_full,
      porta_empty_flag, porta_output_ready, porta_almost_empty}, 6'b111000);
    chk("reset data", porta_data_out, 0);
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      chk("register", rd, rows[i].d);
      chk("slverr", er, rows[i].e);
    end
    $display("test registers done");
    apb(1, 8'h04, 32'h0000_0002); // q1_empty_offset = 2
    for (int i = 2; i < 4; i++) begin
      a_wr <= 1;
      wait (na == i);
      a_wr <= 0;
      repeat (60) @(posedge pclk);
      chk("almost empty", portb_almost_empty, i > 2);
    end
    chk("empty flag", portb_empty_flag, 1);
    a_wr <= 1;
    wait (porta_full_flag === 1'b0);
    a_wr <= 0;
    repeat (60) @(posedge pclk);
    chk("almost full", porta_almost_full, 0);
    chk("input ready", porta_input_ready, 0);
    apb(0, 8'h14, 0);
    chk("status", rd, 32'h0000_003C);
    $display("test fill done");
    for (int i = 8; i < 10; i++) begin
      b_rd <= 1;
      wait (nb == i);
      b_rd <= 0;
      repeat (60) @(posedge pclk);
      chk("almost full drain", porta_almost_full, i > 8);
    end
    chk("space again", porta_full_flag, 1);
    b_rd <= 1;
    wait (portb_empty_flag === 1'b0);
    repeat (60) @(posedge pclk);
    b_rd <= 0;
    chk("held word", portb_data_out, 36'h0_0000_00FF);
    chk("drained", portb_almost_empty, 0);
    $display("test drain done");
    // fall-through: one word into the empty queue shows without a read
    apb(1, 8'h00, 32'h0000_0001);
    a_wr <= 1;
    wait (na == 257);
    a_wr <= 0;
    repeat (60) @(posedge pclk);
    chk("fall through", portb_data_out, 36'h0_0000_0100);
    chk("output ready", portb_output_ready, 1);
    $display("test fall through done");
    end_of_test();
  end
endmodule
bind dfsfl_top dfsfl_sva u_sva (.*);
